// File: acss_pkg.sv
// ==========================================================
// shared constants and carriers for the clock source selector
package acss_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;         // ref_clk_i rate
  localparam int unsigned GATE_TIME_US = 1000;          // measuring window, microseconds
  localparam int unsigned GATE_CYC = GATE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GATE_W = 17;                  // gate counter width
  localparam int unsigned INT_RATE_HZ = 44100;          // internal crystal sample rate
  localparam int unsigned INT_HALF_CYC = CLK_HZ / (2 * INT_RATE_HZ); // rounded down
  localparam int unsigned INT_W = 12;                   // internal divider width

  // ==========================================================
  // measurement limits, in edges per gate window
  localparam logic [15:0] LOCK_MIN = 16'h001C;          // lowest recognised count
  localparam logic [15:0] LOCK_MAX = 16'h00C8;          // highest recognised count
  localparam logic [15:0] RATE_TOL = 16'h0002;          // allowed count deviation
  localparam int unsigned NUM_IN = 3;                   // word, optical, aes

  // ==========================================================
  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RATE = 4'h1;
  localparam logic [3:0] ADDR_STAT_WORD = 4'h2;
  localparam logic [3:0] ADDR_STAT_OPT = 4'h3;
  localparam logic [3:0] ADDR_STAT_AES = 4'h4;
  localparam logic [3:0] ADDR_CUR = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned CTRL_AUTO_BIT = 0;            // 1 = auto follow, 0 = master
  localparam int unsigned CTRL_PREF_LSB = 1;            // 2-bit preferred input index
  localparam logic [2:0] CTRL_RST = 3'h0;               // master, prefer word clock
  localparam logic [15:0] RATE_RST = 16'h002C;          // expected count at reset
  localparam int unsigned IRQ_W = 5;                    // lock change x3, error, source
  localparam int unsigned IRQ_ERR_BIT = 3;
  localparam int unsigned IRQ_SRC_BIT = 4;

  // input index order
  localparam int unsigned IN_WORD = 0;
  localparam int unsigned IN_OPT = 1;
  localparam int unsigned IN_AES = 2;

  // reference in use
  typedef enum logic [1:0] {
    SRC_INT,
    SRC_OPT,
    SRC_AES,
    SRC_WORD
  } acss_src_t;

  // per input status word
  typedef struct packed {
    logic mismatch;
    logic sync;
    logic lock;
    logic [15:0] count;
  } acss_stat_t;

  // software control
  typedef struct packed {
    logic [1:0] pref;
    logic auto_follow_mode;
  } acss_ctrl_t;

endpackage

// File: acss_top.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module acss_top
  import acss_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // recovered clocks from the digital inputs
  input wire logic word_clk_i,
  input wire logic optical_multichannel_input_i,
  input wire logic aes_clk_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // clock outputs and status
  output logic sample_clk_o,
  output logic [1:0] cur_src_o,
  output logic rate_error_o,
  output logic irq_o
);

  // ==========================================================
  // helpers
  // absolute distance between two counts
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // input index to reference code
  function automatic acss_src_t idx_to_src(input logic [1:0] idx);
    case (idx)
      2'h0: idx_to_src = SRC_WORD;
      2'h1: idx_to_src = SRC_OPT;
      2'h2: idx_to_src = SRC_AES;
      default: idx_to_src = SRC_INT;
    endcase
  endfunction

  // ==========================================================
  // registers
  acss_ctrl_t ctrl_reg;            // mode and preferred input
  logic [15:0] rate_reg;           // configured rate as count per window
  logic [IRQ_W-1:0] irq_stat_reg;  // sticky events
  logic [IRQ_W-1:0] irq_en_reg;    // event enables
  logic [31:0] rdata_reg;          // read data, one cycle after strobe
  acss_stat_t stat [NUM_IN];       // per input status
  logic [NUM_IN-1:0] pin_raw;      // raw pin levels
  logic [NUM_IN-1:0] pin_lvl;      // synchronised levels
  logic [NUM_IN-1:0] lock_chg;     // lock changed at window end
  logic [GATE_W-1:0] gate_cnt_reg; // window counter
  logic gate_tick;                 // one-cycle window end pulse
  logic [INT_W-1:0] int_cnt_reg;   // internal crystal divider
  logic int_clk_reg;               // internal sample clock
  acss_src_t want_src;             // reference the selection asks for
  acss_src_t cur_src_reg;          // reference in use
  logic sclk_reg;                  // output sample clock
  logic want_lvl;                  // level of the wanted reference
  logic cur_lvl;                   // level of the reference in use
  logic src_chg;                   // reference changed this cycle
  logic err_any;                   // any locked input at the wrong rate
  logic err_q_reg;                 // previous error level

  assign pin_raw = {aes_clk_i, optical_multichannel_input_i, word_clk_i};

  // ==========================================================
  // measuring window
  // free running gate so all inputs are judged at the same time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_cnt_reg <= '0;
    end else if (gate_tick) begin
      gate_cnt_reg <= '0;
    end else begin
      gate_cnt_reg <= gate_cnt_reg + 1'b1;
    end
  end

  assign gate_tick = (gate_cnt_reg == GATE_W'(GATE_CYCLES - 1));

  // ==========================================================
  // per input receivers, all running in parallel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic s1_reg;                // first synchroniser stage
      logic s2_reg;                // second synchroniser stage
      logic s3_reg;                // edge detect history
      logic [15:0] edge_cnt_reg;   // rising edges in this window
      logic [15:0] meas_reg;       // count of the last window
      logic lock_reg;              // rate recognised and stable
      logic rise;                  // rising edge seen
      logic in_range;              // count is a recognised rate
      logic stable;                // count agrees with last window

      // two flops before any logic looks at the pin
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end

      assign rise = s2_reg & ~s3_reg;
      assign pin_lvl[gi] = s2_reg;

      // edge counter restarted at every window end
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          edge_cnt_reg <= '0;
        end else if (gate_tick) begin
          edge_cnt_reg <= {15'h0000, rise};
        end else if (rise && edge_cnt_reg != 16'hFFFF) begin
          edge_cnt_reg <= edge_cnt_reg + 16'h0001;
        end
      end

      assign in_range = (edge_cnt_reg >= LOCK_MIN) && (edge_cnt_reg <= LOCK_MAX);
      assign stable = (abs_diff(edge_cnt_reg, meas_reg) <= RATE_TOL);

      // window result: a count is only trusted when seen twice
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meas_reg <= '0;
          lock_reg <= 1'b0;
        end else if (gate_tick) begin
          meas_reg <= edge_cnt_reg;
          lock_reg <= in_range && stable;
        end
      end

      assign lock_chg[gi] = gate_tick && (lock_reg != (in_range && stable));

      // status seen by software; no value shown without lock
      always_comb begin
        stat[gi].lock = lock_reg;
        stat[gi].count = lock_reg ? meas_reg : 16'h0000;
        stat[gi].mismatch = lock_reg && (abs_diff(meas_reg, rate_reg) > RATE_TOL);
        stat[gi].sync = lock_reg && !stat[gi].mismatch;
      end
    end
  endgenerate

  // ==========================================================
  // internal crystal clock
  // divider toggles the internal sample clock every half period
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_cnt_reg <= '0;
      int_clk_reg <= 1'b0;
    end else if (int_cnt_reg == INT_W'(INT_HALF_CYC - 1)) begin
      int_cnt_reg <= '0;
      int_clk_reg <= ~int_clk_reg;
    end else begin
      int_cnt_reg <= int_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // reference selection
  // master: internal only; follow: preferred, then priority, then internal
  always_comb begin
    want_src = SRC_INT;
    if (!ctrl_reg.auto_follow_mode) begin
      want_src = SRC_INT;
    end else if (ctrl_reg.pref < 2'(NUM_IN) && stat[ctrl_reg.pref].lock) begin
      want_src = idx_to_src(ctrl_reg.pref);
    end else if (stat[IN_WORD].lock) begin
      want_src = SRC_WORD;
    end else if (stat[IN_OPT].lock) begin
      want_src = SRC_OPT;
    end else if (stat[IN_AES].lock) begin
      want_src = SRC_AES;
    end else begin
      want_src = SRC_INT;
    end
  end

  // level of a reference
  function automatic logic src_level(input acss_src_t s, input logic [NUM_IN-1:0] lv,
                                     input logic il);
    case (s)
      SRC_WORD: src_level = lv[IN_WORD];
      SRC_OPT: src_level = lv[IN_OPT];
      SRC_AES: src_level = lv[IN_AES];
      default: src_level = il;
    endcase
  endfunction

  assign want_lvl = src_level(want_src, pin_lvl, int_clk_reg);
  assign cur_lvl = src_level(cur_src_reg, pin_lvl, int_clk_reg);
  assign src_chg = (want_src != cur_src_reg) && !sclk_reg && !want_lvl;

  // the change waits until the output clock and the new reference are both low, so the
  // output never shows a shortened high phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_src_reg <= SRC_INT;
    end else if (src_chg) begin
      cur_src_reg <= want_src;
    end
  end

  // output clock follows the reference in use, held low across a change
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_reg <= 1'b0;
    end else if (want_src != cur_src_reg && !sclk_reg) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= cur_lvl;
    end
  end

  // ==========================================================
  // error detection
  assign err_any = stat[IN_WORD].mismatch | stat[IN_OPT].mismatch | stat[IN_AES].mismatch;

  // previous error level for a rising event
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q_reg <= 1'b0;
    end else begin
      err_q_reg <= err_any;
    end
  end

  // ==========================================================
  // control registers
  // software writes to mode, preferred input and expected rate
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
      rate_reg <= RATE_RST;
      irq_en_reg <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_CTRL: ctrl_reg <= reg_wdata_i[2:0];
        ADDR_RATE: rate_reg <= reg_wdata_i[15:0];
        ADDR_IRQ_EN: irq_en_reg <= reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // interrupt status
  // events set sticky bits; a set in the clearing cycle wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
                       ~((reg_wr_i && reg_addr_i == ADDR_IRQ_CLR) ?
                         reg_wdata_i[IRQ_W-1:0] : '0)) |
                      {src_chg, err_any & ~err_q_reg, lock_chg};
    end
  end

  // ==========================================================
  // read port
  // data stands for exactly one cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CTRL: rdata_reg <= {29'h00000000, ctrl_reg};
        ADDR_RATE: rdata_reg <= {16'h0000, rate_reg};
        ADDR_STAT_WORD: rdata_reg <= {13'h0000, stat[IN_WORD]};
        ADDR_STAT_OPT: rdata_reg <= {13'h0000, stat[IN_OPT]};
        ADDR_STAT_AES: rdata_reg <= {13'h0000, stat[IN_AES]};
        ADDR_CUR: rdata_reg <= {30'h00000000, cur_src_reg};
        ADDR_IRQ_STAT: rdata_reg <= {27'h0000000, irq_stat_reg};
        ADDR_IRQ_EN: rdata_reg <= {27'h0000000, irq_en_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o = rdata_reg;
  assign sample_clk_o = sclk_reg;
  assign cur_src_o = cur_src_reg;
  assign rate_error_o = err_q_reg;
  assign irq_o = |(irq_stat_reg & irq_en_reg);

endmodule

// File: acss_top_asserts.sv
`timescale 1ns/1ns
// ==========================================================
// port level checks for the clock source selector
module acss_top_asserts
  import acss_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // clock outputs and status
  input wire logic sample_clk_o,
  input wire logic [1:0] cur_src_o,
  input wire logic irq_o
);
  logic st_rd_reg; // a status word was read last cycle
  logic cur_rd_reg; // the current source was read last cycle
  logic auto_reg; // mirror of the auto follow bit
  logic [15:0] rate_reg; // mirror of the expected count
  logic [IRQ_W-1:0] en_reg; // mirror of the interrupt enable
  logic [11:0] mst_reg; // cycles spent in master mode, saturating

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // mirrors of what software wrote and read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_reg <= 1'b0;
      rate_reg <= RATE_RST;
      en_reg <= '0;
    end else if (reg_wr_i) begin
      // only mapped writable places are mirrored
      if (reg_addr_i == ADDR_CTRL) auto_reg <= reg_wdata_i[CTRL_AUTO_BIT];
      if (reg_addr_i == ADDR_RATE) rate_reg <= reg_wdata_i[15:0];
      if (reg_addr_i == ADDR_IRQ_EN) en_reg <= reg_wdata_i[IRQ_W-1:0];
    end
  end

  // read qualifiers and master mode age
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_rd_reg <= 1'b0;
      cur_rd_reg <= 1'b0;
      mst_reg <= 12'h000;
    end else begin
      st_rd_reg <= reg_rd_i && reg_addr_i >= ADDR_STAT_WORD && reg_addr_i <= ADDR_STAT_AES;
      cur_rd_reg <= reg_rd_i && reg_addr_i == ADDR_CUR;
      if (auto_reg) mst_reg <= 12'h000;
      else if (mst_reg != 12'hFFF) mst_reg <= mst_reg + 12'h001;
    end
  end

  // ==========================================================
  // assertions
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_RD_CUR: assert property (cur_rd_reg |-> reg_rdata_o == {30'h0, $past(cur_src_o)})
    else $error("current source read differs from output");
  AST_NOLOCK: assert property (st_rd_reg && !reg_rdata_o[16] |-> reg_rdata_o[15:0] == 16'h0)
    else $error("unlocked input reports a count");
  AST_SYNC_LOCK: assert property (st_rd_reg && reg_rdata_o[17] |-> reg_rdata_o[16])
    else $error("sync without lock");
  AST_SYNC_RATE: assert property (st_rd_reg && reg_rdata_o[17] |->
      reg_rdata_o[15:0] + 16'h2 >= rate_reg && reg_rdata_o[15:0] <= rate_reg + 16'h2)
    else $error("sync reported at a foreign rate");
  AST_MASTER: assert property (mst_reg == 12'hFFF |-> cur_src_o == SRC_INT)
    else $error("master mode not on internal clock");
  AST_SWITCH_LOW: assert property ($changed(cur_src_o) |-> !$past(sample_clk_o))
    else $error("reference changed while sample clock high");
  AST_HIGH_HOLD: assert property ($rose(sample_clk_o) |=> sample_clk_o [*3])
    else $error("runt high pulse on sample clock");
  AST_IRQ_MASK: assert property (en_reg == '0 |-> !irq_o)
    else $error("interrupt with all sources masked");
endmodule

// File: acss_link_src.sv
`timescale 1ns/1ns
// ==========================================================
// far side: recovered clocks of the three digital inputs
module acss_link_src (
  // control from the bench
  input wire logic [2:0] run_i,
  input wire logic [11:0] half_ns_i [3],
  // recovered clocks
  output logic word_clk_o,
  output logic opt_clk_o,
  output logic aes_clk_o
);
  logic lk [3] = '{1'b0, 1'b0, 1'b0}; // clock levels

  // each source toggles while running and rests low when cut off;
  // start offsets keep the first edges away from the sampling clock edges
  for (genvar g = 0; g < 3; g++) begin : g_src
    initial begin
      #(2 + 2 * g);
      forever begin
        if (run_i[g]) begin
          #(half_ns_i[g]);
          lk[g] = ~lk[g];
        end else begin
          lk[g] = 1'b0;
          #7;
        end
      end
    end
  end

  assign word_clk_o = lk[0];
  assign opt_clk_o = lk[1];
  assign aes_clk_o = lk[2];
endmodule

// File: acss_top_tb.sv
`timescale 1ns/1ns
// ==========================================================
// self checking bench for the clock source selector
module acss_top_tb;
  import acss_pkg::*;
  localparam int unsigned GC = 2000; // short window: 125 edges at 160 ns
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic sample_clk_o;
  logic [1:0] cur_src_o;
  logic rate_error_o;
  logic irq_o;
  logic word_clk_i;
  logic optical_multichannel_input_i;
  logic aes_clk_i;
  logic [2:0] run = 3'h7; // all sources running
  logic [11:0] half_ns [3] = '{12'h050, 12'h050, 12'h064}; // 160, 160, 200 ns
  logic [31:0] rd_val; // last read answer
  int err_total = 0;
  int checks_done = 0;

  acss_top #(.GATE_CYCLES(GC)) DUT (.ref_clk_i, .rst_n_i, .word_clk_i,
    .optical_multichannel_input_i, .aes_clk_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .sample_clk_o, .cur_src_o, .rate_error_o, .irq_o);
  acss_link_src LINK (.run_i(run), .half_ns_i(half_ns), .word_clk_o(word_clk_i),
    .opt_clk_o(optical_multichannel_input_i), .aes_clk_o(aes_clk_i));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  // status word: flags are mismatch, sync, lock; count within one edge
  task automatic chk_stat(input logic [3:0] a, input logic [2:0] f, input logic [15:0] c);
    logic [15:0] dev;
    rd(a);
    dev = rd_val[15:0] + 16'h1 - c;
    chk({29'h0, rd_val[18:16]}, {29'h0, f});
    if (c == 16'h0) chk({16'h0, rd_val[15:0]}, 32'h0);
    else chk({31'h0, dev <= 16'h2}, 32'h1);
  endtask
  task automatic wait_src(input logic [1:0] e);
    int n;
    n = 0;
    while (cur_src_o !== e && n < 12000) begin
      @(posedge ref_clk_i);
      n++;
    end
    #1 chk({30'h0, cur_src_o}, {30'h0, e});
  endtask
  // rising edges of the sample clock over a span, within one edge
  task automatic cnt_sclk(input int cyc, input int exp);
    int n;
    logic p;
    n = 0;
    p = sample_clk_o;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if (sample_clk_o === 1'b1 && p === 1'b0) n++;
      p = sample_clk_o;
    end
    chk({31'h0, (n >= exp - 1) && (n <= exp + 1)}, 32'h1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [3:0] a [5] = '{ADDR_CTRL, ADDR_RATE, ADDR_CUR, ADDR_IRQ_EN, 4'hF};
    logic [31:0] e [5] = '{32'h0, {16'h0, RATE_RST}, 32'h0, 32'h0, 32'h0};
    wr(ADDR_CUR, 32'h3); // read-only place ignores the write
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      chk(rd_val, e[i]);
    end
  endtask
  task automatic t_master;
    wr(ADDR_RATE, 32'h7D);
    wr(ADDR_IRQ_EN, 32'h1F);
    repeat (4 * GC) @(posedge ref_clk_i);
    chk_stat(ADDR_STAT_WORD, 3'b011, 16'h7D);
    chk_stat(ADDR_STAT_OPT, 3'b011, 16'h7D);
    chk_stat(ADDR_STAT_AES, 3'b101, 16'h64);
    chk({31'h0, rate_error_o}, 32'h1);
    chk({30'h0, cur_src_o}, {30'h0, SRC_INT});
    chk({31'h0, irq_o}, 32'h1);
    rd(ADDR_IRQ_STAT);
    chk(rd_val, 32'h0F);
    wr(ADDR_IRQ_CLR, 32'h1F);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_auto;
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_CTRL, 32'h3); // auto, prefer optical
    wait_src(SRC_OPT);
    rd(ADDR_CUR);
    chk(rd_val, 32'h1);
    cnt_sclk(320, 20);
    chk({31'h0, irq_o}, 32'h0);
    rd(ADDR_IRQ_STAT);
    chk(rd_val, 32'h10);
    wr(ADDR_IRQ_EN, 32'h10);
    chk({31'h0, irq_o}, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h10);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_CTRL, 32'h5); // prefer aes: locked though off rate
    wait_src(SRC_AES);
    cnt_sclk(400, 20);
  endtask
  task automatic t_prio;
    wr(ADDR_CTRL, 32'h7); // auto, no preference
    wait_src(SRC_WORD);
    run <= 3'h6;
    wait_src(SRC_OPT);
    half_ns[2] <= 12'h3E8; // aes far too slow to recognise
    run <= 3'h4;
    wait_src(SRC_INT);
    chk_stat(ADDR_STAT_WORD, 3'b000, 16'h0);
    chk_stat(ADDR_STAT_AES, 3'b000, 16'h0);
    chk({31'h0, rate_error_o}, 32'h0);
    half_ns[2] <= 12'h064;
    run <= 3'h7;
    wr(ADDR_CTRL, 32'h1); // auto, prefer word
    wait_src(SRC_WORD);
    wr(ADDR_CTRL, 32'h0); // master
    wait_src(SRC_INT);
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_master();
    t_auto();
    t_prio();
    wrap_up();
  end
  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end
endmodule

bind acss_top acss_top_asserts #(.GATE_CYCLES(GATE_CYCLES)) u_chk (.ref_clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_clk_o, .cur_src_o,
  .irq_o);
